// >>> verilog/quad_capture_pkg.sv
package quad_capture_pkg;

	// Widths
	localparam int CNT_W  = 16;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int FLAG_W = 5;
	localparam int CTRL_W = 18;
	localparam int DIV_W  = 3;

	// Clock rates and the period channel timing
	localparam int CLK_MHZ      = 250;
	localparam int TICK_MHZ     = 50;
	localparam int TICK_DIV     = CLK_MHZ / TICK_MHZ;
	localparam int PERIOD_NS    = 1000000;
	localparam int PERIOD_TICKS = PERIOD_NS / 1000 * TICK_MHZ;

	localparam logic [DIV_W-1:0] DIV_LAST    = DIV_W'(TICK_DIV - 1);
	localparam logic [DIV_W-1:0] DIV_STEP    = 3'h1;
	localparam logic [CNT_W-1:0] CNT_MAX     = 16'hffff;
	localparam logic [CNT_W-1:0] CNT_ONE     = 16'h0001;
	localparam logic [CNT_W-1:0] COMPARE_RST = CNT_W'(PERIOD_TICKS - 1);

	// Field codes
	localparam logic [3:0] MODE_PHASE1 = 4'h4;
	localparam logic [2:0] CLR_INDEX   = 3'h1;
	localparam logic [3:0] CAPB_PERIOD = 4'hc;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_FLAGS    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_QCOUNT   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_IDX_CAP  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_PER_CAP  = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_PCOUNT   = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_PCOMPARE = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_EDGE_CAP = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_EDGE_BUF = 8'h24;

	// Control word, low bit first from the bottom of the list
	typedef struct packed {
		logic       pair_alt;
		logic       buffer_en;
		logic [1:0] clock_edge_select;
		logic [2:0] prescaler_select;
		logic [3:0] capture_b_source;
		logic [2:0] counter_clear_source;
		logic [3:0] channel_mode_field;
	} ctrl_type;

	localparam ctrl_type CTRL_RST = '0;

	// Event flags, also the layout of enables and requests
	typedef struct packed {
		logic edge_time;
		logic underflow;
		logic overflow;
		logic period;
		logic index;
	} flag_type;

	localparam flag_type FLAG_RST = '0;

	// Register port request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_req_type;

endpackage : quad_capture_pkg

// >>> verilog/quadrature_counter_capture.sv
module quadrature_counter_capture (
	input  wire logic                          clk_sys,
	input  wire logic                          arst_n,
	input  wire quad_capture_pkg::bus_req_type bus,
	input  wire logic                          quad_phase_a_in,
	input  wire logic                          quad_phase_b_in,
	input  wire logic                          alt_phase_a_in,
	input  wire logic                          alt_phase_b_in,
	input  wire logic                          index_edge_in,
	output logic [quad_capture_pkg::DATA_W-1:0] rdata,
	output quad_capture_pkg::flag_type          irq_req
);
	import quad_capture_pkg::*;

	typedef struct packed {
		ctrl_type          ctrl;
		flag_type          irq_en;
		flag_type          flags;
		flag_type          irq;
		logic [CNT_W-1:0]  quadrature_count;
		logic [CNT_W-1:0]  index_capture_reg;
		logic [CNT_W-1:0]  period_capture_reg;
		logic [CNT_W-1:0]  period_count;
		logic [CNT_W-1:0]  period_compare_reg;
		logic [CNT_W-1:0]  edge_time_capture_reg;
		logic [CNT_W-1:0]  edge_time_buffer_reg;
		logic [DIV_W-1:0]  div;
		logic              primed;
		logic              prev_a;
		logic              prev_b;
		logic              prev_z;
		logic [DATA_W-1:0] rdata;
	} state_type;

	state_type q;
	state_type d;

	// Read decode; unmapped offsets answer zero
	function automatic logic [DATA_W-1:0] read_word(input state_type s,
			input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] w;
		w = '0;
		unique case (a)
			OFS_CTRL:     w = DATA_W'(s.ctrl);
			OFS_IRQ_EN:   w = DATA_W'(s.irq_en);
			OFS_FLAGS:    w = DATA_W'(s.flags);
			OFS_QCOUNT:   w = DATA_W'(s.quadrature_count);
			OFS_IDX_CAP:  w = DATA_W'(s.index_capture_reg);
			OFS_PER_CAP:  w = DATA_W'(s.period_capture_reg);
			OFS_PCOUNT:   w = DATA_W'(s.period_count);
			OFS_PCOMPARE: w = DATA_W'(s.period_compare_reg);
			OFS_EDGE_CAP: w = DATA_W'(s.edge_time_capture_reg);
			OFS_EDGE_BUF: w = DATA_W'(s.edge_time_buffer_reg);
			default:      w = '0;
		endcase
		return w;
	endfunction : read_word

	// Write hit on one register offset
	function automatic logic wr_hit(input bus_req_type b,
			input logic [ADDR_W-1:0] ofs);
		return b.wr && (b.addr == ofs);
	endfunction : wr_hit

	logic phase_a;
	logic phase_b;
	logic in_mode;
	logic a_rise;
	logic a_fall;
	logic b_rise;
	logic b_fall;
	logic step_up;
	logic step_dn;
	logic count_event;
	logic idx_capture;
	logic tick;
	logic match;
	logic period_capture;

	// Input pair choice; prescaler and edge fields never reach the counter
	assign phase_a = q.ctrl.pair_alt ? alt_phase_a_in : quad_phase_a_in;
	assign phase_b = q.ctrl.pair_alt ? alt_phase_b_in : quad_phase_b_in;
	assign in_mode = q.ctrl.channel_mode_field == MODE_PHASE1;

	// Edges against last cycle; first cycle after reset is only a sample
	assign a_rise = q.primed && phase_a && !q.prev_a;
	assign a_fall = q.primed && !phase_a && q.prev_a;
	assign b_rise = q.primed && phase_b && !q.prev_b;
	assign b_fall = q.primed && !phase_b && q.prev_b;

	// Direction table; a double edge in one cycle is dropped as illegal
	assign step_up = in_mode && (
		(b_rise && phase_a && !(a_rise || a_fall)) ||
		(b_fall && !phase_a && !(a_rise || a_fall)) ||
		(a_rise && !phase_b && !(b_rise || b_fall)) ||
		(a_fall && phase_b && !(b_rise || b_fall)));
	assign step_dn = in_mode && (
		(b_fall && phase_a && !(a_rise || a_fall)) ||
		(b_rise && !phase_a && !(a_rise || a_fall)) ||
		(a_rise && phase_b && !(b_rise || b_fall)) ||
		(a_fall && !phase_b && !(b_rise || b_fall)));
	assign count_event = step_up || step_dn;

	// Index edge and period channel events
	assign idx_capture    = q.primed && index_edge_in && !q.prev_z;
	assign tick           = q.div == DIV_LAST;
	assign match          = tick && (q.period_count == q.period_compare_reg);
	assign period_capture = match && (q.ctrl.capture_b_source == CAPB_PERIOD);

	// Next state; hardware flag sets come after the clear so the set wins
	always_comb begin
		d        = q;
		d.primed = 1'b1;
		d.prev_a = phase_a;
		d.prev_b = phase_b;
		d.prev_z = index_edge_in;

		// Software configuration
		if (wr_hit(bus, OFS_CTRL)) begin
			d.ctrl = ctrl_type'(bus.wdata[CTRL_W-1:0]);
		end
		if (wr_hit(bus, OFS_IRQ_EN)) begin
			d.irq_en = flag_type'(bus.wdata[FLAG_W-1:0]);
		end
		if (wr_hit(bus, OFS_PCOMPARE)) begin
			d.period_compare_reg = bus.wdata[CNT_W-1:0];
		end
		if (wr_hit(bus, OFS_FLAGS)) begin
			d.flags = flag_type'(q.flags & ~flag_type'(bus.wdata[FLAG_W-1:0]));
		end

		// Rate divider, one enable in five system clocks
		d.div = tick ? '0 : DIV_W'(q.div + DIV_STEP);

		// Period channel: count, clear on match
		if (tick) begin
			d.period_count = match ? '0 : CNT_W'(q.period_count + CNT_ONE);
		end
		if (wr_hit(bus, OFS_PCOUNT)) begin
			d.period_count = bus.wdata[CNT_W-1:0];
		end
		if (period_capture) begin
			d.period_capture_reg = q.quadrature_count;
			d.flags.period       = 1'b1;
		end

		// Quadrature counter with wrap flags
		if (step_up) begin
			d.quadrature_count = CNT_W'(q.quadrature_count + CNT_ONE);
			if (q.quadrature_count == CNT_MAX) begin
				d.flags.overflow = 1'b1;
			end
		end else if (step_dn) begin
			d.quadrature_count = CNT_W'(q.quadrature_count - CNT_ONE);
			if (q.quadrature_count == '0) begin
				d.flags.underflow = 1'b1;
			end
		end
		if (wr_hit(bus, OFS_QCOUNT)) begin
			d.quadrature_count = bus.wdata[CNT_W-1:0];
		end

		// Timestamp of each count, previous value into the buffer
		if (count_event) begin
			d.edge_time_capture_reg = q.period_count;
			d.flags.edge_time       = 1'b1;
			if (q.ctrl.buffer_en) begin
				d.edge_time_buffer_reg = q.edge_time_capture_reg;
			end
		end

		// Index capture; its clear beats steps and software writes
		if (idx_capture) begin
			d.index_capture_reg = q.quadrature_count;
			d.flags.index       = 1'b1;
			if (q.ctrl.counter_clear_source == CLR_INDEX) begin
				d.quadrature_count = '0;
			end
		end

		// Registered outputs
		d.rdata = bus.rd ? read_word(q, bus.addr) : '0;
		d.irq   = flag_type'(d.flags & d.irq_en);
	end

	// State register
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			q                       <= '0;
			q.ctrl                  <= CTRL_RST;
			q.irq_en                <= FLAG_RST;
			q.flags                 <= FLAG_RST;
			q.irq                   <= FLAG_RST;
			q.period_compare_reg    <= COMPARE_RST;
		end else begin
			q <= d;
		end
	end

	assign rdata   = q.rdata;
	assign irq_req = q.irq;

	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	logic quiet_count;
	assign quiet_count = !idx_capture && !wr_hit(bus, OFS_QCOUNT);

	sequence s_a_rise_b_low;
		q.primed && in_mode && phase_a && !q.prev_a && !phase_b && !q.prev_b;
	endsequence

	sequence s_b_rise_a_low;
		q.primed && in_mode && phase_b && !q.prev_b && !phase_a && !q.prev_a;
	endsequence

	sequence s_tick_gap;
		!tick [*4] ##1 tick;
	endsequence

	sequence s_stamp;
		count_event && q.ctrl.buffer_en;
	endsequence

	AST_UP_STEP: assert property (
		s_a_rise_b_low and (quiet_count [*1])
		|=> q.quadrature_count == CNT_W'($past(q.quadrature_count) + CNT_ONE))
		else $error("count did not rise on A rise with B low");

	AST_DN_STEP: assert property (
		s_b_rise_a_low and (quiet_count [*1])
		|=> q.quadrature_count == CNT_W'($past(q.quadrature_count) - CNT_ONE))
		else $error("count did not fall on B rise with A low");

	AST_WRAP_UP: assert property (
		step_up && quiet_count && q.quadrature_count == CNT_MAX
		|=> q.quadrature_count == '0 && q.flags.overflow)
		else $error("overflow wrap wrong");

	AST_WRAP_DN: assert property (
		step_dn && quiet_count && q.quadrature_count == '0
		|=> q.quadrature_count == CNT_MAX && q.flags.underflow)
		else $error("underflow wrap wrong");

	AST_INDEX: assert property (
		idx_capture && q.ctrl.counter_clear_source == CLR_INDEX
		|=> q.index_capture_reg == $past(q.quadrature_count)
			&& q.quadrature_count == '0 && q.flags.index)
		else $error("index capture or clear wrong");

	AST_TICK_GAP: assert property (
		tick |=> s_tick_gap)
		else $error("period tick spacing wrong");

	AST_PERIOD_CLR: assert property (
		match && !wr_hit(bus, OFS_PCOUNT) |=> q.period_count == '0 ##1 q.period_count == '0)
		else $error("period counter not cleared on match");

	AST_PERIOD_CAP: assert property (
		period_capture |=> q.period_capture_reg == $past(q.quadrature_count)
			&& q.flags.period)
		else $error("period capture wrong");

	AST_STAMP: assert property (
		s_stamp |=> q.edge_time_capture_reg == $past(q.period_count)
			&& q.edge_time_buffer_reg == $past(q.edge_time_capture_reg))
		else $error("edge time stamp or buffer wrong");

	AST_IRQ: assert property (
		count_event && q.irq_en.edge_time && !wr_hit(bus, OFS_IRQ_EN)
		|=> irq_req.edge_time)
		else $error("edge time request missing");

	AST_MODE_OFF: assert property (
		!in_mode && quiet_count |=> $stable(q.quadrature_count))
		else $error("counter moved outside phase mode");

endmodule : quadrature_counter_capture

// >>> test/quad_encoder_model.sv
// Two-phase encoder with index, stepped one quarter cycle per request
module quad_encoder_model (
	input  wire logic clk_sys,
	input  wire logic arst_n,
	input  wire logic step_up,
	input  wire logic step_dn,
	input  wire logic index_req,
	output logic      phase_a,
	output logic      phase_b,
	output logic      index_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] pos_q;

	// Gray walk: only one phase moves per step, never both at once
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pos_q     <= 2'h0;
			index_out <= 1'b0;
		end else begin
			if (step_up) begin
				pos_q <= pos_q + 2'h1;
			end else if (step_dn) begin
				pos_q <= pos_q - 2'h1;
			end
			index_out <= index_req;
		end
	end

	// Going up, A leads B: 00, 10, 11, 01
	assign phase_a = pos_q[0] ^ pos_q[1];
	assign phase_b = pos_q[1];
endmodule : quad_encoder_model

// >>> test/quadrature_counter_capture_test.sv
module quadrature_counter_capture_test;
	import quad_capture_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// Phase mode 1, clear on index, period match capture, buffering on,
	// prescaler and edge bits all set since phase counting must ignore them
	localparam logic [DATA_W-1:0] CTRL_ON = 32'h0001fe14;

	logic              clk_sys;
	logic              arst_n;
	logic              up;
	logic              dn;
	logic              zreq;
	logic              pa;
	logic              pb;
	logic              zo;
	bus_req_type       bus;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] rv;
	logic [DATA_W-1:0] cap;
	flag_type          irq;
	int                err_count;
	int                tests_run;
	int                n;

	quadrature_counter_capture DUT (
		.clk_sys(clk_sys), .arst_n(arst_n), .bus(bus),
		.quad_phase_a_in(pa), .quad_phase_b_in(pb),
		.alt_phase_a_in(1'b0), .alt_phase_b_in(1'b0),
		.index_edge_in(zo), .rdata(rdata), .irq_req(irq)
	);

	quad_encoder_model enc (
		.clk_sys(clk_sys), .arst_n(arst_n), .step_up(up), .step_dn(dn),
		.index_req(zreq), .phase_a(pa), .phase_b(pb), .index_out(zo)
	);

	// 250 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_sys);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
		bus <= '0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk_sys);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
		@(posedge clk_sys);
		bus <= '0;
		@(posedge clk_sys);
		d = rdata;
	endtask : rd

	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		rd(a, rv);
		chk(rv, exp);
	endtask : rchk

	// Ten clocks between steps, i.e. two period ticks at 50 MHz
	task automatic step(input logic u, input int cnt);
		repeat (cnt) begin
			@(posedge clk_sys);
			up <= u;
			dn <= !u;
			@(posedge clk_sys);
			up <= 1'b0;
			dn <= 1'b0;
			repeat (8) @(posedge clk_sys);
		end
	endtask : step

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	// Main sequence
	initial begin
		err_count = 0;
		tests_run = 0;
		arst_n = 1'b0;
		up = 1'b0;
		dn = 1'b0;
		zreq = 1'b0;
		bus = '0;
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		rchk(OFS_PCOMPARE, 32'h0000c34f);
		rchk(8'h30, 32'h0);
		chk(DATA_W'(irq), 32'h0);
		step(1'b1, 1);
		rchk(OFS_QCOUNT, 32'h0);
		$display("reset and mode test done");
		wr(OFS_CTRL, CTRL_ON);
		wr(OFS_IRQ_EN, 32'h1f);
		step(1'b1, 4);
		rchk(OFS_QCOUNT, 32'h4);
		rchk(OFS_FLAGS, 32'h10);
		rd(OFS_EDGE_CAP, cap);
		rd(OFS_EDGE_BUF, rv);
		chk(cap - rv, 32'h2);
		step(1'b0, 5);
		rchk(OFS_QCOUNT, 32'hffff);
		rchk(OFS_FLAGS, 32'h18);
		step(1'b1, 1);
		rchk(OFS_QCOUNT, 32'h0);
		chk(DATA_W'(irq), 32'h1c);
		wr(OFS_IRQ_EN, 32'h04);
		// Request register takes the new mask at the write edge; look one edge on
		@(posedge clk_sys);
		chk(DATA_W'(irq), 32'h04);
		wr(OFS_FLAGS, 32'h1f);
		rchk(OFS_FLAGS, 32'h0);
		wr(OFS_IRQ_EN, 32'h1f);
		$display("count test done");
		wr(OFS_QCOUNT, 32'h0123);
		@(posedge clk_sys);
		zreq <= 1'b1;
		repeat (3) @(posedge clk_sys);
		zreq <= 1'b0;
		rchk(OFS_IDX_CAP, 32'h0123);
		rchk(OFS_QCOUNT, 32'h0);
		chk(DATA_W'(irq), 32'h01);
		wr(OFS_FLAGS, 32'h1f);
		$display("index test done");
		// Short compare so a match comes every 50 clocks
		wr(OFS_PCOUNT, 32'h0);
		wr(OFS_PCOMPARE, 32'h9);
		wr(OFS_QCOUNT, 32'h55);
		wr(OFS_FLAGS, 32'h1f);
		rv = '0;
		n = 0;
		while (rv[1] !== 1'b1 && n < 40) begin
			rd(OFS_FLAGS, rv);
			n++;
		end
		// A missed match counts once and falls through to the one verdict
		if (rv[1] !== 1'b1) begin
			err_count++;
			$display("MISMATCH at %0t: no period match", $time);
		end else begin
			rchk(OFS_PER_CAP, 32'h55);
			chk(DATA_W'(irq) & 32'h2, 32'h2);
			rd(OFS_PCOUNT, rv);
			chk(DATA_W'(rv <= 32'h9), 32'h1);
		end
		$display("period test done");
		// Clear and capture sources off: index captures without clearing,
		// and period matches leave the period capture untouched
		wr(OFS_CTRL, 32'h00010004);
		wr(OFS_QCOUNT, 32'h0077);
		wr(OFS_FLAGS, 32'h1f);
		@(posedge clk_sys);
		zreq <= 1'b1;
		repeat (3) @(posedge clk_sys);
		zreq <= 1'b0;
		rchk(OFS_IDX_CAP, 32'h0077);
		rchk(OFS_QCOUNT, 32'h0077);
		repeat (60) @(posedge clk_sys);
		rchk(OFS_PER_CAP, 32'h55);
		rchk(OFS_FLAGS, 32'h01);
		$display("source select test done");
		stop_test();
	end
endmodule : quadrature_counter_capture_test
